/* rtl/pmic_irq_enable_status_bank.sv */
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

module pmic_irq_enable_status_bank (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register access from the serial interface front end
  input wire irq_bank_pkg::reg_req_t i_req,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // event levels from the analog and pin monitors, asynchronous
  input wire irq_bank_pkg::evt_bank_t i_events,
  // interrupt request, active high
  output logic o_irq
);
  import irq_bank_pkg::*;

  localparam logic [7:0] EN_RST [4] = '{`IRQB_RST_EN_BATTERY_CHARGE, `IRQB_RST_EN_FAULT_KEY,
                                        `IRQB_RST_EN_SUPPLY_STATE, `IRQB_RST_EN_TIMER_PIN_EDGES};
  localparam logic [7:0] MASKS [4] = '{`IRQB_MASK_BATTERY_CHARGE, `IRQB_MASK_FAULT_KEY,
                                       `IRQB_MASK_SUPPLY_STATE, `IRQB_MASK_TIMER_PIN_EDGES};

  logic rst_meta_q;
  logic rst_n_q;
  evt_bank_t evt_meta_q;
  evt_bank_t evt_sync_q;
  evt_bank_t evt_prev_q;
  evt_bank_t evt_rise;
  logic [7:0] en_q [4];
  logic [7:0] st_q [4];
  logic [3:0] en_wr;
  logic [3:0] st_wr;
  logic [3:0] grp_pend;
  reg_hit_t hit;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic irq_q;

  // map an address onto an enable or status register of one group
  function automatic reg_hit_t decode(input logic [7:0] addr);
    logic [7:0] en_ofs;
    logic [7:0] st_ofs;
    reg_hit_t h;
    en_ofs = addr - `IRQB_OFS_EN_BATTERY_CHARGE;
    st_ofs = addr - `IRQB_OFS_ST_BATTERY_CHARGE;
    h.is_en = (en_ofs < 8'h04);
    h.is_st = (st_ofs < 8'h04);
    h.grp = h.is_en ? en_ofs[1:0] : st_ofs[1:0];
    return h;
  endfunction : decode

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // two-flop synchroniser on all event lines; first stage read only by second
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_meta_q <= '0;
      evt_sync_q <= '0;
    end else begin
      evt_meta_q <= i_events;
      evt_sync_q <= evt_meta_q;
    end
  end

  // previous level for edge detection; a level held high sets its flag once only
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_prev_q <= '0;
    end else begin
      evt_prev_q <= evt_sync_q;
    end
  end

  assign evt_rise = evt_sync_q & ~evt_prev_q;

  // address decode of the incoming access
  assign hit = decode(i_req.addr);

  // write strobes per group
  generate
    for (genvar g = 0; g < `IRQB_GROUPS; g++) begin : g_bank
      assign en_wr[g] = i_req.wr && hit.is_en && (hit.grp == 2'(g));
      assign st_wr[g] = i_req.wr && hit.is_st && (hit.grp == 2'(g));
      assign grp_pend[g] = |(en_q[g] & st_q[g]);

      irq_group_bank #(
        .EN_RESET(EN_RST[g]),
        .BIT_MASK(MASKS[g])
      ) u_bank (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n_q),
        .i_en_wr(en_wr[g]),
        .i_st_wr(st_wr[g]),
        .i_wdata(i_req.wdata),
        .i_set(evt_rise[g]),
        .o_enable_q(en_q[g]),
        .o_status_q(st_q[g])
      );
    end
  endgenerate

  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data_q <= 8'h00;
    end else if (i_req.rd) begin
      if (hit.is_en) begin
        rd_data_q <= en_q[hit.grp];
      end else if (hit.is_st) begin
        rd_data_q <= st_q[hit.grp];
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  // read answer marker, one cycle after the request
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_req.rd;
    end
  end

  // request follows the enabled flags one cycle later, registered to avoid glitches
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |grp_pend;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_irq = irq_q;

  // ---- checks ----

  sequence s_en_write(int g);
    i_req.wr && hit.is_en && hit.grp == 2'(g);
  endsequence

  sequence s_st_write_ones(int g);
    i_req.wr && hit.is_st && hit.grp == 2'(g) && i_req.wdata == 8'hff && evt_rise[g] == 8'h00;
  endsequence

  chk_grp2_reset_value: assert property (
    @(posedge i_sys_clk) $rose(rst_n_q) |-> en_q[0] == 8'hff && st_q[0] == 8'h00
  ) else $error("battery enable reset value wrong");

  chk_grp2_en_write: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_en_write(0) |=> en_q[0] == $past(i_req.wdata)
  ) else $error("battery enable write lost");

  chk_grp2_flag_sets: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    evt_rise[0][3] |=> st_q[0][3]
  ) else $error("charging flag not set");

  chk_grp3_reset_value: assert property (
    @(posedge i_sys_clk) $rose(rst_n_q) |-> en_q[1] == 8'h03 && st_q[1] == 8'h00
  ) else $error("fault enable reset value wrong");

  chk_grp3_rsvd_zero: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_en_write(1) |=> en_q[1][`IRQB_BIT_FAULT_KEY_RSVD] == 1'b0 &&
                      en_q[1][4] == $past(i_req.wdata[4])
  ) else $error("fault enable reserved bit writable");

  chk_grp3_flag_sets: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    evt_rise[1][1] |=> st_q[1][1] && !st_q[1][`IRQB_BIT_FAULT_KEY_RSVD]
  ) else $error("short press flag not set");

  chk_grp4_reset_value: assert property (
    @(posedge i_sys_clk) $rose(rst_n_q) |-> en_q[2] == 8'h01 && st_q[2] == 8'h00
  ) else $error("supply enable reset value wrong");

  chk_grp4_flag_sets: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    evt_rise[2][0] |=> st_q[2][0]
  ) else $error("supply low flag not set");

  chk_grp5_reset_value: assert property (
    @(posedge i_sys_clk) $rose(rst_n_q) |-> en_q[3] == 8'h00 && st_q[3] == 8'h00
  ) else $error("timer enable reset value wrong");

  chk_grp5_rsvd_zero: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_en_write(3) |=> en_q[3][`IRQB_BIT_TIMER_PIN_RSVD] == 1'b0 &&
                      en_q[3][7] == $past(i_req.wdata[7])
  ) else $error("timer enable reserved bit writable");

  chk_grp5_flag_sets: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    evt_rise[3][7] |=> st_q[3][7] && !st_q[3][`IRQB_BIT_TIMER_PIN_RSVD]
  ) else $error("timer flag not set");

  chk_w1c_clears: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_st_write_ones(0) |=> st_q[0] == 8'h00
  ) else $error("write one did not clear");

  chk_w0_keeps: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    i_req.wr && hit.is_st && hit.grp == 2'd2 && i_req.wdata == 8'h00
      |=> st_q[2] == ($past(st_q[2]) | $past(evt_rise[2]))
  ) else $error("write zero changed status");

  chk_set_beats_clear: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    st_wr[1] && evt_rise[1][0] |=> st_q[1][0]
  ) else $error("event lost in clearing cycle");

  chk_flag_sticky: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    st_q[3][0] && !st_wr[3] |=> st_q[3][0]
  ) else $error("status bit dropped without clear");

  chk_pin_to_flag: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    $rose(i_events[2][5]) ##1 i_events[2][5] [*3] |-> ##[0:1] st_q[2][5]
  ) else $error("event pin did not reach status");

  chk_irq_follows: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (en_q[0] & st_q[0]) != 8'h00 || (en_q[1] & st_q[1]) != 8'h00 ||
    (en_q[2] & st_q[2]) != 8'h00 || (en_q[3] & st_q[3]) != 8'h00 |=> o_irq
  ) else $error("enabled flag gave no interrupt request");

  chk_irq_masked: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    (en_q[0] & st_q[0]) == 8'h00 && (en_q[1] & st_q[1]) == 8'h00 &&
    (en_q[2] & st_q[2]) == 8'h00 && (en_q[3] & st_q[3]) == 8'h00 |=> !o_irq
  ) else $error("interrupt without enabled flag");

  chk_read_answer: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    i_req.rd && hit.is_st && hit.grp == 2'd0 |=> o_rd_valid && o_rd_data == $past(st_q[0])
  ) else $error("status read returned wrong data");

  chk_read_enable: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    i_req.rd && hit.is_en && hit.grp == 2'd1 |=> o_rd_valid && o_rd_data == $past(en_q[1])
  ) else $error("enable read returned wrong data");

  chk_grp4_en_write: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_en_write(2) |=> en_q[2] == $past(i_req.wdata)
  ) else $error("supply enable write lost");

  chk_grp5_w1c: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_st_write_ones(3) |=> st_q[3] == 8'h00
  ) else $error("timer status not cleared by ones");

  // accesses outside both register ranges; the serial front end may pass any address
  sequence s_unmapped_rd;
    i_req.rd && !hit.is_en && !hit.is_st;
  endsequence

  sequence s_unmapped_wr;
    i_req.wr && !hit.is_en && !hit.is_st;
  endsequence

  chk_unmapped_read: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_unmapped_rd |=> o_rd_valid && o_rd_data == 8'h00
  ) else $error("unmapped read returned data");

  chk_unmapped_write: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    s_unmapped_wr |=> en_q[0] == $past(en_q[0]) && en_q[1] == $past(en_q[1]) &&
                      en_q[2] == $past(en_q[2]) && en_q[3] == $past(en_q[3])
  ) else $error("unmapped write changed an enable");

  chk_rsvd_read_zero: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    !st_q[1][`IRQB_BIT_FAULT_KEY_RSVD] && !en_q[1][`IRQB_BIT_FAULT_KEY_RSVD] &&
    !st_q[3][`IRQB_BIT_TIMER_PIN_RSVD] && !en_q[3][`IRQB_BIT_TIMER_PIN_RSVD]
  ) else $error("reserved bit reads as one");

  chk_rd_valid_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    !i_req.rd |=> !o_rd_valid
  ) else $error("read answer without a read");

  chk_rd_data_holds: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n_q)
    !i_req.rd |=> $stable(o_rd_data)
  ) else $error("read data changed without a read");

endmodule : pmic_irq_enable_status_bank

/* pkg/irq_bank_defines.svh */
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// number of enable/status pairs held here
`define IRQB_GROUPS 4

// enable registers, one per group, consecutive
`define IRQB_OFS_EN_BATTERY_CHARGE 8'h41
`define IRQB_OFS_EN_FAULT_KEY 8'h42
`define IRQB_OFS_EN_SUPPLY_STATE 8'h43
`define IRQB_OFS_EN_TIMER_PIN_EDGES 8'h44

// status registers, one per group, consecutive
`define IRQB_OFS_ST_BATTERY_CHARGE 8'h49
`define IRQB_OFS_ST_FAULT_KEY 8'h4a
`define IRQB_OFS_ST_SUPPLY_STATE 8'h4b
`define IRQB_OFS_ST_TIMER_PIN_EDGES 8'h4c

// reset values of the enable registers
`define IRQB_RST_EN_BATTERY_CHARGE 8'hff
`define IRQB_RST_EN_FAULT_KEY 8'h03
`define IRQB_RST_EN_SUPPLY_STATE 8'h01
`define IRQB_RST_EN_TIMER_PIN_EDGES 8'h00

// reset value of every status register
`define IRQB_RST_STATUS 8'h00

// implemented bit masks; reserved positions are zero
`define IRQB_MASK_BATTERY_CHARGE 8'hff
`define IRQB_MASK_FAULT_KEY 8'hdf
`define IRQB_MASK_SUPPLY_STATE 8'hff
`define IRQB_MASK_TIMER_PIN_EDGES 8'hef

// field positions of the reserved bits
`define IRQB_BIT_FAULT_KEY_RSVD 5
`define IRQB_BIT_TIMER_PIN_RSVD 4

`endif

/* pkg/irq_bank_pkg.sv */
package irq_bank_pkg;

  // one register access as delivered by the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // decoded register hit
  typedef struct packed {
    logic is_en;
    logic is_st;
    logic [1:0] grp;
  } reg_hit_t;

  // event lines of the four groups, index 0 is the battery/charge group
  typedef logic [3:0][7:0] evt_bank_t;

endpackage : irq_bank_pkg

/* rtl/irq_group_bank.sv */
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

module irq_group_bank #(
  parameter logic [7:0] EN_RESET = 8'h00,
  parameter logic [7:0] BIT_MASK = 8'hff
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // register writes
  input wire logic i_en_wr,
  input wire logic i_st_wr,
  input wire logic [7:0] i_wdata,
  // event set pulses
  input wire logic [7:0] i_set,
  // register contents
  output logic [7:0] o_enable_q,
  output logic [7:0] o_status_q
);

  logic [7:0] status_d;

  // enable register; reserved bits held at zero so they read back as zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_enable_q <= EN_RESET & BIT_MASK;
    end else if (i_en_wr) begin
      o_enable_q <= i_wdata & BIT_MASK;
    end
  end

  // write-one-to-clear; a set in the clearing cycle survives the clear
  always_comb begin
    status_d = o_status_q;
    if (i_st_wr) begin
      status_d = status_d & ~i_wdata;
    end
    status_d = (status_d | i_set) & BIT_MASK;
  end

  // status register, sticky until cleared
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status_q <= `IRQB_RST_STATUS;
    end else begin
      o_status_q <= status_d;
    end
  end

endmodule : irq_group_bank

/* verif/irq_host_model.sv */
`timescale 1ns/1ps

module irq_host_model (
  // clock
  input wire logic i_sys_clk,
  // register access towards the block
  output irq_bank_pkg::reg_req_t o_req
);
  import irq_bank_pkg::*;

  // idle bus at time zero, before the first edge can sample it
  initial begin
    o_req = '0;
  end

  // one strobe per call; consecutive calls make back-to-back accesses
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data}; // handled flags cleared by ones
  endtask : write_reg

  // read strobe held until the next call or idle, which ends it after one cycle as the port expects
  task automatic read_reg(input logic [7:0] addr);
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
  endtask : read_reg

  // release: address and data flip so a stale value cannot pass for a held one
  task automatic idle();
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
  endtask : idle
endmodule : irq_host_model

/* verif/pmic_irq_enable_status_bank_bench.sv */
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

module pmic_irq_enable_status_bank_bench;
  import irq_bank_pkg::*;

  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  reg_req_t host_req;
  evt_bank_t i_events = '0;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic o_irq;
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'h2aa8;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] masks [4] = '{`IRQB_MASK_BATTERY_CHARGE, `IRQB_MASK_FAULT_KEY,
    `IRQB_MASK_SUPPLY_STATE, `IRQB_MASK_TIMER_PIN_EDGES};
  logic [7:0] en_rst [4] = '{`IRQB_RST_EN_BATTERY_CHARGE, `IRQB_RST_EN_FAULT_KEY,
    `IRQB_RST_EN_SUPPLY_STATE, `IRQB_RST_EN_TIMER_PIN_EDGES};

  // 250 MHz
  always #2 i_sys_clk = ~i_sys_clk;

  pmic_irq_enable_status_bank u_dut (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_req(host_req),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .i_events(i_events),
    .o_irq(o_irq)
  );

  irq_host_model u_host (
    .i_sys_clk(i_sys_clk),
    .o_req(host_req)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // the note goes in before the strobe so the monitor never pops an empty queue
  task automatic read_expect(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.read_reg(addr);
  endtask : read_expect

  // irq is registered, so look at it half a cycle after the edge;
  // return on a rising edge so later stimulus stays edge aligned
  task automatic irq_check(input logic exp);
    @(negedge i_sys_clk);
    check({7'h00, o_irq}, {7'h00, exp});
    @(posedge i_sys_clk);
  endtask : irq_check

  // read data monitor: valid stands one cycle, sampled mid-cycle where it is settled
  always @(negedge i_sys_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected at %0t: read data with nothing pending", $time);
      end else begin
        check(o_rd_data, exp_q.pop_front());
      end
    end
  end

  // hang guard, well above the roughly 135 cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    logic [7:0] en;
    logic [7:0] ev;
    logic [7:0] clr;
    logic [7:0] st;
    repeat (10) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    // reset values back to back, then an unmapped write and two unmapped reads
    for (int k = 0; k < 4; k++) begin
      read_expect(8'(8'h41 + k), en_rst[k]);
      read_expect(8'(8'h49 + k), 8'h00);
    end
    u_host.write_reg(8'h45, 8'hff);
    read_expect(8'h45, 8'h00);
    read_expect(8'h40, 8'h00);
    u_host.idle();
    irq_check(1'b0);
    // a held level sets its flag once; zeros keep it, a one clears it
    i_events[0] <= 8'h01;
    repeat (5) @(posedge i_sys_clk);
    irq_check(1'b1);
    u_host.write_reg(8'h49, 8'hfe);
    read_expect(8'h49, 8'h01);
    u_host.write_reg(8'h49, 8'h01);
    read_expect(8'h49, 8'h00);
    u_host.idle();
    i_events[0] <= 8'h00;
    repeat (3) @(posedge i_sys_clk);
    irq_check(1'b0);
    // random enables and events per group; reserved and checked positions always poked
    for (int k = 0; k < 4; k++) begin
      repeat (8) rnd = lfsr(rnd);
      en = rnd[7:0] | 8'h30;
      ev = rnd[15:8] | 8'hbb;
      clr = rnd[23:16];
      st = ev & masks[k];
      u_host.write_reg(8'(8'h41 + k), en);
      read_expect(8'(8'h41 + k), en & masks[k]);
      u_host.idle();
      i_events[k] <= ev;
      repeat (6) @(posedge i_sys_clk);
      i_events[k] <= 8'h00;
      irq_check(|(st & en));
      read_expect(8'(8'h49 + k), st);
      u_host.write_reg(8'(8'h49 + k), clr);
      read_expect(8'(8'h49 + k), st & ~clr);
      u_host.write_reg(8'(8'h49 + k), 8'hff);
      read_expect(8'(8'h49 + k), 8'h00);
      u_host.idle();
      repeat (2) @(posedge i_sys_clk);
      irq_check(1'b0);
    end
    // an event in the clearing cycle survives; writing zeros keeps a flag
    i_events[1] <= 8'h01;
    i_events[2] <= 8'h01;
    @(posedge i_sys_clk);
    u_host.write_reg(8'h4a, 8'hff);
    read_expect(8'h4a, 8'h01);
    u_host.write_reg(8'h4b, 8'h00);
    read_expect(8'h4b, 8'h01);
    u_host.write_reg(8'h4a, 8'h01);
    u_host.write_reg(8'h4b, 8'h01);
    read_expect(8'h4a, 8'h00);
    read_expect(8'h4b, 8'h00);
    u_host.idle();
    i_events[1] <= 8'h00;
    i_events[2] <= 8'h00;
    repeat (2) @(posedge i_sys_clk);
    irq_check(1'b0);
    repeat (4) @(posedge i_sys_clk);
    check(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule : pmic_irq_enable_status_bank_bench
